// [rtl/video_output_stream_defines.vh]
`ifndef VIDEO_OUTPUT_STREAM_DEFINES_VH
`define VIDEO_OUTPUT_STREAM_DEFINES_VH

// register byte offsets
`define OFF_CONFIG 8'h00
`define OFF_CONTROL 8'h04
`define OFF_VBASE0 8'h08
`define OFF_VBASE1 8'h0c
`define OFF_VBASE2 8'h10
`define OFF_STRIDE 8'h14
`define OFF_BBASE0 8'h18
`define OFF_BBASE1 8'h1c
`define OFF_BBASE2 8'h20
`define OFF_VRANGE 8'h24
`define OFF_BRANGE 8'h28
`define OFF_HOST_IDX 8'h2c
`define OFF_ENGINE_IDX 8'h30
`define OFF_STATUS 8'h34
`define OFF_FIFO_TUNING 8'h38

// stream_config bits
`define CFG_LINE_POL 0
`define CFG_FRAME_POL 1
`define CFG_QUAL_POL 2
`define CFG_FIELD_EN 3
`define CFG_FIELD_POL 4
`define CFG_INTERLACE_VALID 5
`define CFG_BLANK_GATING 6
`define CFG_YUV_CONVERT 7
`define CFG_GAMMA 8
`define CFG_DUAL_EDGE 9
`define CFG_SWAP_BYTES 10
`define CFG_BGR 11
`define CFG_INTERLACED 12

// output_stream_control bits
`define CTL_ENABLE 0
`define CTL_VIDEO_EN 1
`define CTL_BLANK_EN 2
`define CTL_THREE_BUF 3
`define CTL_MERGE 4
`define CTL_FOLLOW 5
`define CTL_FMT_LO 6
`define CTL_FMT_HI 10
`define CTL_COMP_SWAP 11

// stream_status bits
`define ST_BAD_FIELD 0
`define ST_UNDERFLOW 1
`define ST_HIST_LO 2
`define ST_HIST_HI 4

// reset values
`define CONFIG_RST 32'h0000_0000
`define CONTROL_RST 32'h0000_0000
`define TUNING_RST 32'h0000_0000
`define HOST_IDX_RST 2'h0
`define ENGINE_IDX_RST 2'h2

// pixel formats
`define FMT_OFF_FRONT 5'h0b
`define FMT_OFF_BACK 5'h0c
`define FMT_OFFSET 32'h0000_0040
`define FMT_YUV422 5'h13

`endif

// [rtl/pixel_unpack.v]
`timescale 1ns/1ps
`include "video_output_stream_defines.vh"
module pixel_unpack (
	input wire [31:0] mem_word,
	input wire [4:0] format_code,
	input wire component_swap,
	input wire gamma_enable,
	input wire bgr_order,
	output reg [7:0] luma,
	output reg [7:0] chroma_u,
	output reg [7:0] chroma_v,
	output wire [15:0] rgb_word
);
	reg [31:0] w;
	reg [4:0] rp, gp, bp, tp;
	reg [3:0] rw, gw, bw;
	reg [7:0] r, g, b;
	reg signed [17:0] ys, us, vs;

	function [7:0] expand;
		input [31:0] word;
		input [4:0] pos;
		input [3:0] wid;
		reg [31:0] t;
		begin
			t = (word >> pos) & ((32'h0000_0001 << wid) - 32'h0000_0001);
			expand = t[7:0] << (4'd8 - wid);
		end
	endfunction

	function [7:0] gam;
		input [7:0] x;
		reg [15:0] p;
		begin
			p = x * (8'hff - x);
			gam = x + {1'b0, p[15:9]};
		end
	endfunction

	always @* begin
		if (format_code == `FMT_OFF_FRONT || format_code == `FMT_OFF_BACK)
			w = mem_word - `FMT_OFFSET;
		else
			w = mem_word;
		case (format_code)
		5'h00: begin rw = 4'd8; rp = 5'd0; gw = 4'd8; gp = 5'd8; bw = 4'd8; bp = 5'd16; end
		5'h01: begin rw = 4'd5; rp = 5'd0; gw = 4'd5; gp = 5'd5; bw = 4'd5; bp = 5'd10; end
		5'h02: begin rw = 4'd4; rp = 5'd0; gw = 4'd4; gp = 5'd4; bw = 4'd4; bp = 5'd8; end
		5'h05: begin rw = 4'd3; rp = 5'd0; gw = 4'd3; gp = 5'd3; bw = 4'd2; bp = 5'd6; end
		5'h06: begin rw = 4'd3; rp = 5'd8; gw = 4'd3; gp = 5'd11; bw = 4'd2; bp = 5'd14; end
		5'h09, 5'h0b: begin rw = 4'd2; rp = 5'd0; gw = 4'd3; gp = 5'd2; bw = 4'd2; bp = 5'd5; end
		5'h0a, 5'h0c: begin rw = 4'd2; rp = 5'd8; gw = 4'd3; gp = 5'd10; bw = 4'd2; bp = 5'd13; end
		5'h0d: begin rw = 4'd5; rp = 5'd16; gw = 4'd5; gp = 5'd21; bw = 4'd5; bp = 5'd26; end
		5'h10: begin rw = 4'd5; rp = 5'd0; gw = 4'd6; gp = 5'd5; bw = 4'd5; bp = 5'd11; end
		5'h11: begin rw = 4'd5; rp = 5'd16; gw = 4'd6; gp = 5'd21; bw = 4'd5; bp = 5'd27; end
		5'h13: begin rw = 4'd8; rp = 5'd0; gw = 4'd8; gp = 5'd8; bw = 4'd8; bp = 5'd8; end
		default: begin rw = 4'd8; rp = 5'd0; gw = 4'd8; gp = 5'd8; bw = 4'd8; bp = 5'd16; end
		endcase
		tp = rp;
		if (component_swap && format_code == `FMT_YUV422) begin
			rp = 5'd8;
			gp = 5'd0;
			bp = 5'd0;
		end else if (component_swap) begin
			// swapped: blue at the base, then green, then red
			bp = tp;
			gp = tp + {1'b0, bw};
			rp = tp + {1'b0, bw} + {1'b0, gw};
		end
		r = expand(w, rp, rw);
		g = expand(w, gp, gw);
		b = expand(w, bp, bw);
		if (gamma_enable && format_code != `FMT_YUV422) begin
			r = gam(r);
			g = gam(g);
			b = gam(b);
		end
		ys = 18'sd66 * $signed({10'd0, r}) + 18'sd129 * $signed({10'd0, g})
			+ 18'sd25 * $signed({10'd0, b}) + 18'sd128;
		us = 18'sd112 * $signed({10'd0, b}) - 18'sd38 * $signed({10'd0, r})
			- 18'sd74 * $signed({10'd0, g}) + 18'sd128;
		vs = 18'sd112 * $signed({10'd0, r}) - 18'sd94 * $signed({10'd0, g})
			- 18'sd18 * $signed({10'd0, b}) + 18'sd128;
		if (format_code == `FMT_YUV422) begin
			luma = r;
			chroma_u = g;
			chroma_v = b;
		end else begin
			luma = ys[15:8] + 8'h10;
			chroma_u = us[15:8] + 8'h80;
			chroma_v = vs[15:8] + 8'h80;
		end
	end

	assign rgb_word = bgr_order ? {b[7:3], g[7:2], r[7:3]} :
		{r[7:3], g[7:2], b[7:3]};
endmodule

// [rtl/video_output_stream.v]
// How it works
// - output only; YUV422 or RGB, optional gamma then RGB-to-YUV.
// - RGB words are 16 bits, 5-6-5, in RGB or BGR order.
// - byte order Y-U-Y-V, or U-Y-V-Y when swapped_byte_order set.
// - base chosen from 2 or 3 registers by index, stepped per field/frame.
// - engine index never steps onto the host index, except when follow_input_stream copies it.
// - reset: host index 0, engine index 2; video and blank pairs.
// - follow_input_stream copies the input stream's buffer indices.
// - frame_reference loads next base and clears the line counter.
// - line_reference steps the address by one stride, or two strides for video lines when fields are merged.
// - blank-interval lines from own area, raw, no conversion.
// - video needs region and qualifier; blank only if gating set.
// - pin polarities, field pin, odd/even from frame timing.
// - dual_edge_transfer sends on both pixel clock edges.
// - disabled video or blank data is discarded.
// - buffer_count_select picks two or three buffer rotation.
// - merge_fields outputs both fields before the index steps.
// - format code plus swap bit place components in the word.
// - offset formats subtract 64 before unpacking.
// - three bases, stride, video and blank valid-line registers.
// - bad field sequence flagged; last three field types kept.
// - dry read buffer reports underflow; tuning register kept.
// - stream disabled holds output_stream_reset_n low.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "video_output_stream_defines.vh"
module video_output_stream #(
	parameter LW = 12,
	parameter CW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	input wire line_reference,
	input wire frame_reference,
	input wire active_video_qualifier,
	input wire field_signal,
	input wire output_pixel_clock,
	input wire [1:0] input_stream_video_index,
	input wire [1:0] input_stream_blank_index,
	output reg mem_req,
	output reg [31:0] mem_addr,
	input wire mem_ack,
	input wire [31:0] mem_rdata,
	output reg [15:0] output_stream_bus,
	output reg output_data_valid,
	output wire output_stream_reset_n
);
	reg [31:0] stream_config, output_stream_control, output_fifo_tuning;
	reg [31:0] stride, video_range, blank_range;
	reg [31:0] vbase [0:2];
	reg [31:0] bbase [0:2];
	reg [1:0] host_video_index, host_blank_index;
	reg [1:0] engine_video_index, engine_blank_index;
	reg bad_field_sequence, underflow;
	reg [2:0] field_hist;

	wire wr = psel & penable & pwrite;
	wire setup = psel & ~penable;
	wire en = output_stream_control[`CTL_ENABLE];
	wire interlaced = stream_config[`CFG_INTERLACED];
	wire merge = output_stream_control[`CTL_MERGE];
	wire three = output_stream_control[`CTL_THREE_BUF];
	wire follow = output_stream_control[`CTL_FOLLOW];
	wire yuv_mode = stream_config[`CFG_YUV_CONVERT];

	assign pready = 1'b1;
	assign output_stream_reset_n = en;

	// three-stage pin sampling; a level counts once stages two and three agree
	wire [4:0] pins = {output_pixel_clock, field_signal,
		active_video_qualifier, frame_reference, line_reference};
	reg [4:0] s1, s2, s3, filt, filt_q;
	genvar i;
	generate
		for (i = 0; i < 5; i = i + 1) begin : sync
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1[i] <= 1'b0;
					s2[i] <= 1'b0;
					s3[i] <= 1'b0;
					filt[i] <= 1'b0;
					filt_q[i] <= 1'b0;
				end else begin
					s1[i] <= pins[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i])
						filt[i] <= s2[i];
					filt_q[i] <= filt[i];
				end
			end
		end
	endgenerate

	wire [2:0] pol = {stream_config[`CFG_QUAL_POL],
		stream_config[`CFG_FRAME_POL], stream_config[`CFG_LINE_POL]};
	wire [2:0] lev = filt[2:0] ^ pol;
	wire [2:0] lev_q = filt_q[2:0] ^ pol;
	wire line_start = lev[0] & ~lev_q[0];
	wire frame_start = lev[1] & ~lev_q[1];
	wire qual = lev[2];
	wire field_pin = filt[3] ^ stream_config[`CFG_FIELD_POL];
	wire clk_rise = filt[4] & ~filt_q[4];
	wire clk_fall = ~filt[4] & filt_q[4];
	wire strobe = clk_rise | (stream_config[`CFG_DUAL_EDGE] & clk_fall);

	// line period measure for odd/even detection
	reg [CW-1:0] since_line, half_line;
	reg field_q;
	reg [LW-1:0] line_count;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_line <= {CW{1'b0}};
			half_line <= {CW{1'b0}};
		end else if (line_start) begin
			since_line <= {CW{1'b0}};
			half_line <= since_line >> 1;
		end else if (since_line != {CW{1'b1}}) begin
			since_line <= since_line + 1'b1;
		end
	end

	// field type of the starting field
	reg field_now;
	always @* begin
		if (stream_config[`CFG_FIELD_EN])
			field_now = field_pin;
		else if (interlaced && stream_config[`CFG_INTERLACE_VALID])
			field_now = (since_line >= half_line);
		else
			field_now = ~field_q;
	end

	function [1:0] step;
		input [1:0] idx;
		input three_buf;
		begin
			if (idx >= (three_buf ? 2'd2 : 2'd1))
				step = 2'd0;
			else
				step = idx + 2'd1;
		end
	endfunction
	function [1:0] clamp;
		input [1:0] idx;
		begin
			clamp = (idx == 2'd3) ? 2'd0 : idx;
		end
	endfunction

	wire advance = ~interlaced | ~merge | ~field_now;
	wire [1:0] vstep = step(engine_video_index, three);
	wire [1:0] bstep = step(engine_blank_index, three);
	reg [1:0] next_vidx, next_bidx;
	always @* begin
		next_vidx = engine_video_index;
		next_bidx = engine_blank_index;
		if (follow) begin
			next_vidx = clamp(input_stream_video_index);
			next_bidx = clamp(input_stream_blank_index);
		end else if (advance) begin
			if (vstep != host_video_index)
				next_vidx = vstep;
			if (bstep != host_blank_index)
				next_bidx = bstep;
		end
	end

	// merged fields: second field starts one line in, double step
	wire merged = interlaced & merge;
	wire [31:0] line_step = merged ? {stride[30:0], 1'b0} : stride;
	wire [31:0] field_off = (merged & field_now) ? stride : 32'h0000_0000;

	wire [LW-1:0] next_line = line_count + 1'b1;
	wire in_video = line_count >= video_range[LW-1:0] &&
		line_count <= video_range[LW+15:16];
	wire in_blank = line_count >= blank_range[LW-1:0] &&
		line_count <= blank_range[LW+15:16];
	wire nxt_blank = next_line >= blank_range[LW-1:0] &&
		next_line <= blank_range[LW+15:16];
	wire blank_on = in_blank & output_stream_control[`CTL_BLANK_EN];
	wire video_on = ~in_blank & in_video & output_stream_control[`CTL_VIDEO_EN];
	wire blank_go = blank_on & (qual | ~stream_config[`CFG_BLANK_GATING]);
	wire video_go = video_on & qual;
	wire xfer = en & strobe & (blank_go | video_go);

	reg [31:0] vline_addr, bline_addr, cur_addr, word;
	reg word_valid, drop;
	reg [1:0] phase;
	wire [7:0] luma, chroma_u, chroma_v;
	wire [15:0] rgb_word;

	pixel_unpack unpack (
		.mem_word(word),
		.format_code(output_stream_control[`CTL_FMT_HI:`CTL_FMT_LO]),
		.component_swap(output_stream_control[`CTL_COMP_SWAP]),
		.gamma_enable(stream_config[`CFG_GAMMA]),
		.bgr_order(stream_config[`CFG_BGR]),
		.luma(luma),
		.chroma_u(chroma_u),
		.chroma_v(chroma_v),
		.rgb_word(rgb_word)
	);

	wire swap = stream_config[`CFG_SWAP_BYTES];
	wire chroma_phase = phase[0] ^ swap;
	wire [7:0] yuv_byte = ~chroma_phase ? luma :
		(phase[1] ? chroma_v : chroma_u);
	wire consume = ~yuv_mode | blank_on | phase[0];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_count <= {LW{1'b0}};
			field_q <= 1'b0;
			field_hist <= 3'h0;
			engine_video_index <= `ENGINE_IDX_RST;
			engine_blank_index <= `ENGINE_IDX_RST;
			vline_addr <= 32'h0000_0000;
			bline_addr <= 32'h0000_0000;
			cur_addr <= 32'h0000_0000;
			word <= 32'h0000_0000;
			word_valid <= 1'b0;
			drop <= 1'b0;
			phase <= 2'h0;
			mem_req <= 1'b0;
			mem_addr <= 32'h0000_0000;
			output_stream_bus <= 16'h0000;
			output_data_valid <= 1'b0;
		end else begin
			output_data_valid <= 1'b0;
			if (mem_ack & mem_req) begin
				mem_req <= 1'b0;
				drop <= 1'b0;
				if (!drop) begin
					word <= mem_rdata;
					word_valid <= 1'b1;
				end
			end else if (en & ~mem_req & ~word_valid & (blank_on | video_on)) begin
				mem_req <= 1'b1;
				mem_addr <= cur_addr;
				cur_addr <= cur_addr + 32'h0000_0004;
			end
			if (frame_start) begin
				line_count <= {LW{1'b0}};
				field_q <= field_now;
				field_hist <= {field_hist[1:0], field_now};
				engine_video_index <= next_vidx;
				engine_blank_index <= next_bidx;
				vline_addr <= vbase[next_vidx] + field_off;
				bline_addr <= bbase[next_bidx];
				word_valid <= 1'b0;
				drop <= mem_req & ~mem_ack;
				phase <= 2'h0;
			end else if (line_start) begin
				line_count <= next_line;
				if (nxt_blank) begin
					cur_addr <= bline_addr;
					bline_addr <= bline_addr + stride;
				end else begin
					cur_addr <= vline_addr;
					vline_addr <= vline_addr + line_step;
				end
				word_valid <= 1'b0;
				drop <= mem_req & ~mem_ack;
				phase <= 2'h0;
			end else if (xfer & word_valid) begin
				output_data_valid <= 1'b1;
				if (blank_on)
					output_stream_bus <= word[15:0];
				else if (yuv_mode)
					output_stream_bus <= {8'h00, yuv_byte};
				else
					output_stream_bus <= rgb_word;
				if (consume)
					word_valid <= 1'b0;
				if (yuv_mode & ~blank_on)
					phase <= phase + 2'h1;
			end
		end
	end

	// sticky flags, a new event beats the clear
	wire bad_seq = frame_start & interlaced & (field_now == field_q);
	wire dry = xfer & ~word_valid & ~frame_start & ~line_start;
	wire st_clr = wr && paddr == `OFF_STATUS;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bad_field_sequence <= 1'b0;
			underflow <= 1'b0;
		end else begin
			bad_field_sequence <= bad_seq |
				(bad_field_sequence & ~(st_clr & pwdata[`ST_BAD_FIELD]));
			underflow <= dry |
				(underflow & ~(st_clr & pwdata[`ST_UNDERFLOW]));
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stream_config <= `CONFIG_RST;
			output_stream_control <= `CONTROL_RST;
			output_fifo_tuning <= `TUNING_RST;
			stride <= 32'h0000_0000;
			video_range <= 32'h0000_0000;
			blank_range <= 32'h0000_0000;
			vbase[0] <= 32'h0000_0000;
			vbase[1] <= 32'h0000_0000;
			vbase[2] <= 32'h0000_0000;
			bbase[0] <= 32'h0000_0000;
			bbase[1] <= 32'h0000_0000;
			bbase[2] <= 32'h0000_0000;
			host_video_index <= `HOST_IDX_RST;
			host_blank_index <= `HOST_IDX_RST;
		end else if (wr) begin
			case (paddr)
			`OFF_CONFIG: stream_config <= pwdata;
			`OFF_CONTROL: output_stream_control <= pwdata;
			`OFF_VBASE0: vbase[0] <= pwdata;
			`OFF_VBASE1: vbase[1] <= pwdata;
			`OFF_VBASE2: vbase[2] <= pwdata;
			`OFF_STRIDE: stride <= pwdata;
			`OFF_BBASE0: bbase[0] <= pwdata;
			`OFF_BBASE1: bbase[1] <= pwdata;
			`OFF_BBASE2: bbase[2] <= pwdata;
			`OFF_VRANGE: video_range <= pwdata;
			`OFF_BRANGE: blank_range <= pwdata;
			`OFF_HOST_IDX: begin
				host_video_index <= clamp(pwdata[1:0]);
				host_blank_index <= clamp(pwdata[3:2]);
			end
			`OFF_FIFO_TUNING: output_fifo_tuning <= pwdata;
			default: ;
			endcase
		end
	end

	// read data captured in the setup cycle
	reg [31:0] rd;
	reg rd_err;
	always @* begin
		rd = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
		`OFF_CONFIG: rd = stream_config;
		`OFF_CONTROL: rd = output_stream_control;
		`OFF_VBASE0: rd = vbase[0];
		`OFF_VBASE1: rd = vbase[1];
		`OFF_VBASE2: rd = vbase[2];
		`OFF_STRIDE: rd = stride;
		`OFF_BBASE0: rd = bbase[0];
		`OFF_BBASE1: rd = bbase[1];
		`OFF_BBASE2: rd = bbase[2];
		`OFF_VRANGE: rd = video_range;
		`OFF_BRANGE: rd = blank_range;
		`OFF_HOST_IDX: rd = {28'h000_0000, host_blank_index, host_video_index};
		`OFF_ENGINE_IDX: rd = {28'h000_0000, engine_blank_index,
			engine_video_index};
		`OFF_STATUS: rd = {27'h000_0000, field_hist, underflow,
			bad_field_sequence};
		`OFF_FIFO_TUNING: rd = output_fifo_tuning;
		default: rd_err = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rd;
			pslverr <= rd_err;
		end
	end
endmodule

// [bench/video_output_stream_sva.sv]
`timescale 1ns/1ps
`include "video_output_stream_defines.vh"
module video_output_stream_sva #(
	parameter LW = 12,
	parameter CW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire line_reference,
	input wire frame_reference,
	input wire active_video_qualifier,
	input wire field_signal,
	input wire output_pixel_clock,
	input wire [1:0] input_stream_video_index,
	input wire [1:0] input_stream_blank_index,
	input wire mem_req,
	input wire [31:0] mem_addr,
	input wire mem_ack,
	input wire [31:0] mem_rdata,
	input wire [15:0] output_stream_bus,
	input wire output_data_valid,
	input wire output_stream_reset_n
);
	logic pix_d;
	logic [3:0] since_pix;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// cycles since the pixel clock pin last moved
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_d <= 1'b0;
			since_pix <= 4'hf;
		end else begin
			pix_d <= output_pixel_clock;
			if (pix_d != output_pixel_clock)
				since_pix <= 4'h0;
			else if (since_pix != 4'hf)
				since_pix <= since_pix + 4'h1;
		end
	end
	sequence s_ctl_write;
		psel && penable && pwrite && paddr == `OFF_CONTROL;
	endsequence
	sequence s_mem_wait;
		mem_req && !mem_ack;
	endsequence
	a_enable_raises: assert property (
		(s_ctl_write ##0 pwdata[0]) |=> output_stream_reset_n)
		else $error("stream reset not released on enable");
	a_disable_lowers: assert property (
		(s_ctl_write ##0 !pwdata[0]) |=> !output_stream_reset_n)
		else $error("stream reset not asserted on disable");
	a_idle_silent: assert property (
		!output_stream_reset_n ##1 !output_stream_reset_n
		|-> !output_data_valid)
		else $error("transfer while stream disabled");
	a_valid_pulse: assert property (
		output_data_valid |=> !output_data_valid)
		else $error("valid longer than one cycle");
	a_valid_after_edge: assert property (
		output_data_valid |-> since_pix <= 4'hc)
		else $error("transfer without a pixel clock edge");
	a_bus_holds: assert property (
		!$stable(output_stream_bus) |-> output_data_valid)
		else $error("pixel bus moved without a transfer");
	a_mem_holds: assert property (
		s_mem_wait |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped or moved");
	a_mem_drops: assert property (
		mem_req && mem_ack |=> !mem_req)
		else $error("memory request held after ack");
	a_mem_aligned: assert property (
		mem_req |-> mem_addr[1:0] == 2'h0)
		else $error("memory address not word aligned");
	a_unmapped_err: assert property (
		psel && !penable && paddr > `OFF_FIFO_TUNING |=> pslverr)
		else $error("no error for unmapped address");
endmodule
bind video_output_stream video_output_stream_sva #(.LW(LW), .CW(CW)) u_sva (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr),
	.line_reference(line_reference), .frame_reference(frame_reference),
	.active_video_qualifier(active_video_qualifier),
	.field_signal(field_signal), .output_pixel_clock(output_pixel_clock),
	.input_stream_video_index(input_stream_video_index),
	.input_stream_blank_index(input_stream_blank_index),
	.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
	.mem_rdata(mem_rdata), .output_stream_bus(output_stream_bus),
	.output_data_valid(output_data_valid),
	.output_stream_reset_n(output_stream_reset_n)
);

// [bench/video_encoder_model.sv]
`timescale 1ns/1ps
module video_encoder_model (
	output logic line_reference,
	output logic frame_reference,
	output logic active_video_qualifier,
	output logic output_pixel_clock
);
	initial begin
		line_reference = 1'b0;
		frame_reference = 1'b0;
		active_video_qualifier = 1'b0;
		output_pixel_clock = 1'b0;
	end
	task automatic frame();
		#7.3;
		frame_reference = 1'b1;
		#64;
		frame_reference = 1'b0;
		#200;
	endtask
	// line marker, qualifier, clock inside line only
	task automatic line(input int np, input logic q);
		#7.3;
		line_reference = 1'b1;
		#64;
		line_reference = 1'b0;
		#200;
		active_video_qualifier = q;
		repeat (np) begin
			output_pixel_clock = 1'b1;
			#16;
			output_pixel_clock = 1'b0;
			#16;
		end
		#100;
		active_video_qualifier = 1'b0;
		#200;
	endtask
endmodule

// [bench/video_output_stream_test.sv]
`timescale 1ns/1ps
`include "video_output_stream_defines.vh"
module video_output_stream_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr, mem_rdata, rd, first_addr;
	logic mem_req, mem_ack, output_data_valid, output_stream_reset_n;
	logic [15:0] output_stream_bus, first_bus;
	logic err, got_addr, mem_stall;
	wire line_reference, frame_reference, active_video_qualifier;
	wire output_pixel_clock;
	int fails, cmp_count, nvalid;
	typedef struct {logic [7:0] a; logic [31:0] d, e; logic r;} row_t;
	row_t rows[14] = '{
		'{`OFF_VBASE0, 32'h0000_2000, 32'h0000_2000, 1'b0},
		'{`OFF_VBASE1, 32'h0000_3000, 32'h0000_3000, 1'b0},
		'{`OFF_VBASE2, 32'h0000_4000, 32'h0000_4000, 1'b0},
		'{`OFF_STRIDE, 32'h0000_0100, 32'h0000_0100, 1'b0},
		'{`OFF_BBASE0, 32'h0000_1000, 32'h0000_1000, 1'b0},
		'{`OFF_BBASE1, 32'h0000_5000, 32'h0000_5000, 1'b0},
		'{`OFF_BBASE2, 32'h0000_6000, 32'h0000_6000, 1'b0},
		'{`OFF_VRANGE, 32'h0004_0003, 32'h0004_0003, 1'b0},
		'{`OFF_BRANGE, 32'h0002_0001, 32'h0002_0001, 1'b0},
		'{`OFF_FIFO_TUNING, 32'h0000_0033, 32'h0000_0033, 1'b0},
		'{`OFF_CONFIG, 32'h0000_0041, 32'h0000_0041, 1'b0},
		'{`OFF_HOST_IDX, 32'h0000_000f, 32'h0000_0000, 1'b0},
		'{`OFF_ENGINE_IDX, 32'h0000_0005, 32'h0000_000a, 1'b0},
		'{8'h3c, 32'h0000_1234, 32'h0000_0000, 1'b1}};
	video_output_stream DUT (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.line_reference(line_reference),
		.frame_reference(frame_reference),
		.active_video_qualifier(active_video_qualifier),
		.field_signal(1'b0), .output_pixel_clock(output_pixel_clock),
		.input_stream_video_index(2'h0),
		.input_stream_blank_index(2'h0),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .output_stream_bus(output_stream_bus),
		.output_data_valid(output_data_valid),
		.output_stream_reset_n(output_stream_reset_n));
	video_encoder_model ENC (
		.line_reference(line_reference),
		.frame_reference(frame_reference),
		.active_video_qualifier(active_video_qualifier),
		.output_pixel_clock(output_pixel_clock));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// memory answers one cycle after a request unless stalled
	always @(posedge pclk) begin
		mem_ack <= mem_req && !mem_ack && !mem_stall;
		mem_rdata <= mem_addr ^ 32'h0000_5a5a;
		if (output_data_valid) begin
			if (nvalid == 0)
				first_bus = output_stream_bus;
			nvalid++;
		end
		if (mem_req && mem_ack && !got_addr) begin
			first_addr = mem_addr;
			got_addr = 1'b1;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic idx_is(input logic [31:0] e);
		apb(1'b0, `OFF_ENGINE_IDX, 32'h0000_0000);
		chk(rd, e);
	endtask
	task automatic run_rows();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			chk({31'h0, err}, {31'h0, rows[i].r});
			apb(1'b0, rows[i].a, 32'h0000_0000);
			chk(rd, rows[i].e);
			chk({31'h0, err}, {31'h0, rows[i].r});
		end
	endtask
	task automatic do_line(input int np, input logic q, input int n);
		nvalid = 0;
		got_addr = 1'b0;
		ENC.line(np, q);
		chk(nvalid, n);
	endtask
	task automatic report_and_stop();
		$display("compares %0d errors %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100_000;
		fails++;
		report_and_stop();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		mem_stall = 1'b0;
		mem_ack = 1'b0;
		mem_rdata = 32'h0000_0000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		run_rows();
		// reset again mid-run
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		idx_is(32'h0000_000a);
		apb(1'b0, `OFF_HOST_IDX, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({31'h0, output_stream_reset_n}, 32'h0000_0000);
		run_rows();
		wr(`OFF_CONFIG, 32'h0000_0000);
		wr(`OFF_CONTROL, 32'h0000_040f);
		@(posedge pclk);
		chk({31'h0, output_stream_reset_n}, 32'h0000_0001);
		ENC.frame();
		idx_is(32'h0000_000a);
		wr(`OFF_HOST_IDX, 32'h0000_0005);
		ENC.frame();
		idx_is(32'h0000_0000);
		ENC.frame();
		idx_is(32'h0000_0000);
		wr(`OFF_CONTROL, 32'h0000_0407);
		wr(`OFF_HOST_IDX, 32'h0000_000a);
		ENC.frame();
		idx_is(32'h0000_0005);
		ENC.frame();
		idx_is(32'h0000_0000);
		wr(`OFF_HOST_IDX, 32'h0000_0005);
		wr(`OFF_CONTROL, 32'h0000_040f);
		ENC.frame();
		do_line(4, 1'b0, 4);
		chk(first_addr, 32'h0000_1000);
		chk({16'h0000, first_bus}, 32'h0000_4a5a);
		do_line(4, 1'b0, 4);
		chk(first_addr, 32'h0000_1100);
		chk({16'h0000, first_bus}, 32'h0000_4b5a);
		do_line(4, 1'b1, 4);
		do_line(4, 1'b0, 0);
		do_line(4, 1'b1, 0);
		wr(`OFF_CONFIG, 32'h0000_0200);
		ENC.frame();
		do_line(0, 1'b0, 0);
		do_line(0, 1'b0, 0);
		do_line(4, 1'b1, 8);
		wr(`OFF_CONTROL, 32'h0000_040d);
		do_line(4, 1'b1, 0);
		wr(`OFF_CONFIG, 32'h0000_0000);
		wr(`OFF_CONTROL, 32'h0000_040b);
		ENC.frame();
		do_line(4, 1'b0, 0);
		wr(`OFF_CONTROL, 32'h0000_040f);
		ENC.frame();
		do_line(0, 1'b0, 0);
		do_line(0, 1'b0, 0);
		mem_stall = 1'b1;
		do_line(4, 1'b1, 0);
		mem_stall = 1'b0;
		apb(1'b0, `OFF_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_0003, 32'h0000_0002);
		wr(`OFF_STATUS, 32'h0000_0002);
		apb(1'b0, `OFF_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_0003, 32'h0000_0000);
		// swapped 5:6:5 word already has red on top, so it passes as is
		wr(`OFF_CONTROL, 32'h0000_0c0f);
		ENC.frame();
		do_line(0, 1'b0, 0);
		do_line(0, 1'b0, 0);
		do_line(4, 1'b1, 4);
		chk({16'h0000, first_bus},
			{16'h0000, first_addr[15:0] ^ 16'h5a5a});
		wr(`OFF_CONTROL, 32'h0000_0000);
		@(posedge pclk);
		chk({31'h0, output_stream_reset_n}, 32'h0000_0000);
		ENC.frame();
		do_line(4, 1'b1, 0);
		report_and_stop();
	end
endmodule
